/* psu_fault_supervisor.sv */
// Contract
// - OR-ing FET drive only while pulse good.
// - Low line, blanking enabled: line bad, output good.
// - Soft-start ramps reference in 127 steps.
// - Auxiliary overvoltage acts as local overvoltage.
// - Auxiliary lockout acts as local undervoltage.
// - Auto-restart retries after undervoltage every second.
// - No auto-restart for any other fault.
// - Reference monitor faults are flagged.
// - Open ground latches off like overvoltage.
// - Reference buffer off until upper lockout level.
// - Supply health needs ground, references, supply window.
// - Load overvoltage drops FET drive, not latched.
// - Local overvoltage counts only after load overvoltage.
// - Overcurrent flag disables the false-undervoltage clamp.
// - Host programs thresholds through trim registers.
// - Undervoltage blanked at power-up and low line.
// - Overcurrent, overtemperature share the overvoltage latch.
// - Fault inputs debounced, 16 us and 450 us.
// - Output good drops, power enable 2 ms later.
`timescale 1ns/100ps
`default_nettype none
module psu_fault_supervisor #(
  parameter int UV_FILT_CYC = psu_pkg::UV_FILT_CYC,
  parameter int RESTART_CYC = psu_pkg::RESTART_CYC,
  parameter int OFF_DELAY_CYC = psu_pkg::OFF_DELAY_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire psu_pkg::cmp_in_t cmp_in,
  output logic orfet_drive_out,
  output logic line_good_out,
  output logic output_good_out,
  output logic power_enable_out,
  output logic ref_buffer_en_out,
  output logic supply_health_ok,
  output logic clamp_enable_out,
  output logic fault_flag_out,
  output logic [6:0] soft_start_ref_out,
  output var psu_pkg::trim_t trim_out
);
  //////////////////////////////////////////////////////////////////////////////
  // Input conditioning.

  // The filters also synchronise, so no logic here reads a raw pin.
  logic [psu_pkg::N_IN-1:0] raw; // Comparator levels as a vector.
  logic [psu_pkg::N_IN-1:0] f; // Synchronised and filtered levels.

  assign raw = cmp_in;

  // Each input gets its own filter; undervoltage-class inputs use the long window.
  for (genvar i = 0; i < psu_pkg::N_IN; i++) begin : g_filt
    fault_filter #(
      .CYC(psu_pkg::LONG_FILT_MASK[i] ? UV_FILT_CYC : psu_pkg::OV_FILT_CYC)
    ) u_filt (
      .sys_clk(sys_clk),
      .reset(reset),
      .raw(raw[i]),
      .clean(f[i])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register file over Avalon-MM.

  // Software-visible control, trim and divider registers.
  logic [1:0] ctrl_q; // Auto-restart and blanking disable.
  psu_pkg::trim_t trim_q; // Threshold trims.
  logic [15:0] ss_div_q; // Soft-start step divider.
  logic wait_q; // Waitrequest; low for exactly one cycle per access.
  logic [31:0] rdata_q; // Read data, valid while waitrequest is low.
  logic [31:0] rdata_d; // Read mux.
  logic [31:0] status; // Live status word.
  logic acc_go; // Write access completes at this edge.
  logic hit_ctrl;
  logic hit_stat;
  logic hit_uv;
  logic hit_ov;
  logic hit_lov;
  logic hit_clamp;
  logic hit_ss;

  // One match per register; the shared function keeps the decode uniform.
  assign hit_ctrl = psu_pkg::reg_hit(avs_address, psu_pkg::REG_CTRL);
  assign hit_stat = psu_pkg::reg_hit(avs_address, psu_pkg::REG_STATUS);
  assign hit_uv = psu_pkg::reg_hit(avs_address, psu_pkg::REG_TRIM_UV);
  assign hit_ov = psu_pkg::reg_hit(avs_address, psu_pkg::REG_TRIM_OV);
  assign hit_lov = psu_pkg::reg_hit(avs_address, psu_pkg::REG_TRIM_LOV);
  assign hit_clamp = psu_pkg::reg_hit(avs_address, psu_pkg::REG_TRIM_CLAMP);
  assign hit_ss = psu_pkg::reg_hit(avs_address, psu_pkg::REG_SS_DIV);
  assign acc_go = avs_write && !wait_q;

  // Unmapped addresses read zero and ignore writes.
  assign rdata_d = hit_ctrl ? {30'h0, ctrl_q} :
                   hit_stat ? status :
                   hit_uv ? {24'h0, trim_q.uv} :
                   hit_ov ? {24'h0, trim_q.ov} :
                   hit_lov ? {24'h0, trim_q.load_ov} :
                   hit_clamp ? {24'h0, trim_q.clamp} :
                   hit_ss ? {16'h0, ss_div_q} : 32'h0;

  // One wait state: the request is seen, then waitrequest falls for one cycle.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else if (wait_q && (avs_read || avs_write)) begin
      wait_q <= 1'b0;
      rdata_q <= rdata_d;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // Writes land at the edge where waitrequest is sampled low.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= psu_pkg::CTRL_RST;
      trim_q <= {4{psu_pkg::TRIM_RST}};
      ss_div_q <= psu_pkg::SS_DIV_RST;
    end else if (acc_go) begin
      if (hit_ctrl) ctrl_q <= avs_writedata[1:0];
      if (hit_uv) trim_q.uv <= avs_writedata[7:0];
      if (hit_ov) trim_q.ov <= avs_writedata[7:0];
      if (hit_lov) trim_q.load_ov <= avs_writedata[7:0];
      if (hit_clamp) trim_q.clamp <= avs_writedata[7:0];
      if (hit_ss) ss_div_q <= avs_writedata[15:0];
    end
  end

  // Bus outputs come straight from their registers.
  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  assign trim_out = trim_q;

  //////////////////////////////////////////////////////////////////////////////
  // Fault classification.

  logic auto_rs; // Auto-restart mode selected.
  logic uvb_dis; // Undervoltage blanking disabled.
  logic load_ov_seen_q; // Load overvoltage has been observed this run.
  logic latch_q; // Shared overvoltage/overcurrent/overtemperature latch.
  logic latch_d;
  logic uv_pend_q; // The current shutdown came from undervoltage.
  logic ov_trip; // Any overvoltage-class event.
  logic latch_trip; // Any event for the shared latch except undervoltage, which latches only outside auto mode.
  logic uv_blank; // Undervoltage protection blanked.
  logic uv_trip; // Unblanked undervoltage event.
  logic req; // Filtered power-on request.
  psu_pkg::state_t state_q;
  psu_pkg::state_t state_d;

  // Control bits and the filtered request, named for readability.
  assign auto_rs = ctrl_q[psu_pkg::CTRL_AUTO];
  assign uvb_dis = ctrl_q[psu_pkg::CTRL_UVB_DIS];
  assign req = f[psu_pkg::I_PWR_REQ];
  // Local overvoltage is only believed once load overvoltage came first.
  assign ov_trip = (f[psu_pkg::I_LOCAL_OV] && load_ov_seen_q)
                || f[psu_pkg::I_AUX_OV]
                || f[psu_pkg::I_GND_POS]
                || f[psu_pkg::I_IREF_OV] || f[psu_pkg::I_EREF_UV];
  assign latch_trip = ov_trip || f[psu_pkg::I_OC] || f[psu_pkg::I_OT];
  // Blanked while ramping, at low line unless disabled, and during overcurrent ride-through.
  assign uv_blank = (state_q == psu_pkg::S_RAMP)
                 || (!f[psu_pkg::I_LINE] && !uvb_dis)
                 || f[psu_pkg::I_OC];
  assign uv_trip = (f[psu_pkg::I_LOCAL_UV] || f[psu_pkg::I_AUX_UV]) && !uv_blank;
  // Set wins over clear; clearing needs the request released.
  assign latch_d = latch_trip || (uv_trip && (state_q == psu_pkg::S_ON) && !auto_rs)
                || (latch_q && req);

  // Fault latch and the run-scoped load overvoltage memory.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      latch_q <= 1'b0;
      load_ov_seen_q <= 1'b0;
      uv_pend_q <= 1'b0;
    end else begin
      latch_q <= latch_d;
      if (f[psu_pkg::I_LOAD_OV]) load_ov_seen_q <= 1'b1;
      else if (state_q == psu_pkg::S_OFF) load_ov_seen_q <= 1'b0;
      if (uv_trip && (state_q == psu_pkg::S_ON)) uv_pend_q <= 1'b1;
      else if (state_q == psu_pkg::S_OFF) uv_pend_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  // One timer serves both the warning delay and the restart interval.
  logic [26:0] timer_q; // Cycles spent in a timed state.
  logic off_done; // Warning delay elapsed.
  logic rs_done; // Restart interval elapsed.
  logic ss_done; // Reference at full scale.
  logic health_d; // Supply health combination.

  // The timer is zero on entry, so a count of N ends at N minus one.
  assign off_done = (timer_q == 27'(OFF_DELAY_CYC - 1));
  assign rs_done = (timer_q == 27'(RESTART_CYC - 1));
  // Health needs ground, both references and the supply window together.
  assign health_d = !f[psu_pkg::I_GND_POS] && !f[psu_pkg::I_IREF_OV]
                 && !f[psu_pkg::I_EREF_UV] && f[psu_pkg::I_AUX_UP] && !f[psu_pkg::I_AUX_OV];

  // Next state; restart is only reachable from an undervoltage shutdown.
  always_comb begin
    state_d = state_q;
    case (state_q)
      psu_pkg::S_OFF: begin
        if (req && health_d && !latch_q) state_d = psu_pkg::S_RAMP;
      end
      psu_pkg::S_RAMP: begin
        if (latch_trip || !req) state_d = psu_pkg::S_WARN;
        else if (ss_done) state_d = psu_pkg::S_ON;
      end
      psu_pkg::S_ON: begin
        if (latch_trip || uv_trip || !req) state_d = psu_pkg::S_WARN;
      end
      psu_pkg::S_WARN: begin
        if (off_done) begin
          if (latch_q) state_d = psu_pkg::S_LATCHED;
          else if (uv_pend_q && auto_rs) state_d = psu_pkg::S_RESTART;
          else state_d = psu_pkg::S_OFF;
        end
      end
      psu_pkg::S_LATCHED: begin
        if (!latch_q) state_d = psu_pkg::S_OFF;
      end
      psu_pkg::S_RESTART: begin
        if (latch_q) state_d = psu_pkg::S_LATCHED;
        else if (rs_done) state_d = psu_pkg::S_OFF;
      end
      default: state_d = psu_pkg::S_OFF;
    endcase
  end

  // State register and the shared delay timer, cleared on each transition.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= psu_pkg::S_OFF;
      timer_q <= 27'h0;
    end else begin
      state_q <= state_d;
      timer_q <= (state_d != state_q) ? 27'h0 : timer_q + 27'h1;
    end
  end

  // The reference ramp runs in the ramp and on states and holds at full scale when on.
  soft_start_ramp u_ramp (
    .sys_clk(sys_clk),
    .reset(reset),
    .run((state_q == psu_pkg::S_RAMP) || (state_q == psu_pkg::S_ON)),
    .div(ss_div_q),
    .level(soft_start_ref_out),
    .done(ss_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered.

  // Output flops; each mirrors a decision taken above.
  logic orfet_q;
  logic line_good_q;
  logic out_good_q;
  logic pen_q;
  logic ref_en_q;
  logic health_q;
  logic clamp_q;

  // Output good falls on entering the warning state; enable falls after the delay.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      orfet_q <= 1'b0;
      line_good_q <= 1'b0;
      out_good_q <= 1'b0;
      pen_q <= 1'b0;
      ref_en_q <= 1'b0;
      health_q <= 1'b0;
      clamp_q <= 1'b0;
    end else begin
      orfet_q <= (state_d == psu_pkg::S_ON) && f[psu_pkg::I_PULSE]
              && !f[psu_pkg::I_LOAD_OV];
      line_good_q <= f[psu_pkg::I_LINE];
      out_good_q <= (state_d == psu_pkg::S_ON);
      pen_q <= (state_d == psu_pkg::S_RAMP) || (state_d == psu_pkg::S_ON)
            || (state_d == psu_pkg::S_WARN);
      ref_en_q <= ref_en_q || f[psu_pkg::I_AUX_UP];
      health_q <= health_d;
      clamp_q <= !f[psu_pkg::I_OC];
    end
  end

  // Every top-level output is a flop, so no pin glitches on a decode.
  assign orfet_drive_out = orfet_q;
  assign line_good_out = line_good_q;
  assign output_good_out = out_good_q;
  assign power_enable_out = pen_q;
  assign ref_buffer_en_out = ref_en_q;
  assign supply_health_ok = health_q;
  assign clamp_enable_out = clamp_q;
  assign fault_flag_out = latch_q;

  // Bit 7 is reserved and reads zero, which puts the ramp code at bits 14 to 8.
  assign status = {17'h0, soft_start_ref_out, 1'b0, load_ov_seen_q, f[psu_pkg::I_LINE],
                   health_q, latch_q, 3'(state_q)};

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_orfet_pulse: assert property (@(posedge sys_clk) disable iff (reset)
    !f[psu_pkg::I_PULSE] |=> !orfet_q) else $error("FET driven without pulse good");
  // FET removal is checked always; the latch only when nothing else could set it.
  chk_load_ov_drop: assert property (@(posedge sys_clk) disable iff (reset)
    f[psu_pkg::I_LOAD_OV] |=> !orfet_q) else $error("FET driven during load overvoltage");
  chk_load_ov_free: assert property (@(posedge sys_clk) disable iff (reset)
    (f[psu_pkg::I_LOAD_OV] && !latch_trip && !uv_trip && !latch_q) |=> !latch_q)
    else $error("load overvoltage latched");
  chk_low_line: assert property (@(posedge sys_clk) disable iff (reset)
    (!f[psu_pkg::I_LINE] && !uvb_dis && state_q == psu_pkg::S_ON && !latch_trip && req)
    |=> !line_good_q && out_good_q) else $error("low line status wrong");
  chk_aux_ov_latch: assert property (@(posedge sys_clk) disable iff (reset)
    f[psu_pkg::I_AUX_OV] |=> latch_q) else $error("aux overvoltage did not latch");
  chk_gnd_latch: assert property (@(posedge sys_clk) disable iff (reset)
    f[psu_pkg::I_GND_POS] |=> latch_q && !health_q) else $error("open ground not latched");
  chk_restart_cause: assert property (@(posedge sys_clk) disable iff (reset)
    (state_d == psu_pkg::S_RESTART && state_q == psu_pkg::S_WARN) |-> uv_pend_q && auto_rs && !latch_q)
    else $error("restart without undervoltage");
  chk_ref_hold: assert property (@(posedge sys_clk) disable iff (reset)
    (!ref_en_q && !f[psu_pkg::I_AUX_UP]) |=> !ref_en_q) else $error("reference buffer early");
  chk_clamp_oc: assert property (@(posedge sys_clk) disable iff (reset)
    f[psu_pkg::I_OC] |=> !clamp_q) else $error("clamp active in overcurrent");
  chk_good_first: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(pen_q) |-> !out_good_q && !$past(out_good_q)) else $error("enable fell before output good");
  chk_latch_holds: assert property (@(posedge sys_clk) disable iff (reset)
    (latch_q && req) |=> latch_q) else $error("latch cleared while requested");
endmodule
`default_nettype wire

/* psu_pkg.sv */
package psu_pkg;
  // Core clock rate; every delay below is derived from it.
  localparam int CLK_MHZ = 125;
  // Overvoltage filter window in ns, rounded up to whole cycles.
  localparam int OV_FILT_NS = 16000;
  localparam int OV_FILT_CYC = (OV_FILT_NS * CLK_MHZ + 999) / 1000;
  // Undervoltage filter window in us.
  localparam int UV_FILT_US = 450;
  localparam int UV_FILT_CYC = UV_FILT_US * CLK_MHZ;
  // Auto-restart interval in ms.
  localparam int RESTART_MS = 1000;
  localparam int RESTART_CYC = RESTART_MS * CLK_MHZ * 1000;
  // Output-good to power-enable warning delay in us.
  localparam int OFF_DELAY_US = 2000;
  localparam int OFF_DELAY_CYC = OFF_DELAY_US * CLK_MHZ;
  // Soft-start reference steps.
  localparam logic [6:0] SS_STEPS = 7'h7f;
  // Comparator input indices, matching cmp_in_t bit order.
  localparam int I_PULSE = 0;
  localparam int I_LINE = 1;
  localparam int I_LOAD_OV = 2;
  localparam int I_LOCAL_OV = 3;
  localparam int I_LOCAL_UV = 4;
  localparam int I_AUX_OV = 5;
  localparam int I_AUX_UV = 6;
  localparam int I_AUX_UP = 7;
  localparam int I_IREF_OV = 8;
  localparam int I_EREF_UV = 9;
  localparam int I_GND_POS = 10;
  localparam int I_OC = 11;
  localparam int I_OT = 12;
  localparam int I_PWR_REQ = 13;
  localparam int N_IN = 14;
  // Inputs that use the long (undervoltage-class) filter.
  localparam logic [13:0] LONG_FILT_MASK = 14'h2052;
  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TRIM_UV = 8'h08;
  localparam logic [7:0] REG_TRIM_OV = 8'h0c;
  localparam logic [7:0] REG_TRIM_LOV = 8'h10;
  localparam logic [7:0] REG_TRIM_CLAMP = 8'h14;
  localparam logic [7:0] REG_SS_DIV = 8'h18;
  // Control field positions and reset values.
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_UVB_DIS = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [7:0] TRIM_RST = 8'h80;
  localparam logic [15:0] SS_DIV_RST = 16'h03e8;
  // Status field positions.
  localparam int ST_LATCH = 3;
  localparam int ST_HEALTH = 4;
  localparam int ST_LINE = 5;
  localparam int ST_LOADOV = 6;
  localparam int ST_SS = 8;

  // Raw comparator inputs, bit 13 first.
  typedef struct packed {
    logic pwr_req;
    logic ot;
    logic oc;
    logic gnd_pos;
    logic eref_uv;
    logic iref_ov;
    logic aux_up;
    logic aux_uv;
    logic aux_ov;
    logic local_uv;
    logic local_ov;
    logic load_ov;
    logic line_ok;
    logic pulse_good;
  } cmp_in_t;

  // Threshold trims sent to the analog comparators.
  typedef struct packed {
    logic [7:0] uv;
    logic [7:0] ov;
    logic [7:0] load_ov;
    logic [7:0] clamp;
  } trim_t;

  // Supervisor sequencing states.
  typedef enum logic [2:0] {S_OFF, S_RAMP, S_ON, S_WARN, S_LATCHED, S_RESTART} state_t;

  // Address match used by the register decoder for every register.
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction
endpackage

/* fault_filter.sv */
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser followed by a stability filter.
module fault_filter #(
  parameter int CYC = psu_pkg::OV_FILT_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic raw,
  output logic clean
);
  logic s1_q; // First stage, read only by the second.
  logic s2_q; // Second stage, safe to use.
  logic [26:0] cnt_q; // Cycles the input has differed from the output.
  logic clean_q; // Filtered level.
  localparam logic [26:0] LAST = 27'(CYC - 1);

  // Synchronise the comparator level to the core clock.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  // Output follows only after the new level has held for the whole window.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 27'h0;
      clean_q <= 1'b0;
    end else if (s2_q == clean_q) begin
      cnt_q <= 27'h0;
    end else if (cnt_q == LAST) begin
      cnt_q <= 27'h0;
      clean_q <= s2_q;
    end else begin
      cnt_q <= cnt_q + 27'h1;
    end
  end

  assign clean = clean_q;

  chk_filter_window: assert property (@(posedge sys_clk) disable iff (reset)
    $changed(clean_q) |-> ($past(cnt_q) == LAST)) else $error("filter output moved early");
endmodule
`default_nettype wire

/* soft_start_ramp.sv */
`timescale 1ns/100ps
`default_nettype none
// Steps the voltage-loop reference from zero to full scale while run is high.
module soft_start_ramp (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [15:0] div,
  output logic [6:0] level,
  output logic done
);
  logic [15:0] pre_q; // Step-rate divider.
  logic [6:0] level_q; // Reference DAC code.
  logic tick; // One-cycle step enable.

  assign tick = run && (pre_q >= div);
  assign level = level_q;
  assign done = (level_q == psu_pkg::SS_STEPS);

  // Divider and step counter; the ramp restarts from zero each time run drops.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pre_q <= 16'h0;
      level_q <= 7'h0;
    end else if (!run) begin
      pre_q <= 16'h0;
      level_q <= 7'h0;
    end else if (tick) begin
      pre_q <= 16'h0;
      if (!done) begin
        level_q <= level_q + 7'h1;
      end
    end else begin
      pre_q <= pre_q + 16'h1;
    end
  end

  chk_ramp_step: assert property (@(posedge sys_clk) disable iff (reset)
    (tick && !done) |=> (level_q == $past(level_q) + 7'h1)) else $error("soft-start step missed");
endmodule
`default_nettype wire

/* psu_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////
// Stands in for the analog comparators and the host status lines.
// Each level changes only at a clock edge, so every change is asynchronous to nothing.
module psu_host_model (
  input wire logic sys_clk,
  input wire psu_pkg::cmp_in_t want,
  output var psu_pkg::cmp_in_t cmp_in
);
  // The bench asks for a level and the comparator reports it one edge later.
  always @(posedge sys_clk) begin
    cmp_in <= want;
  end
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic avs_waitrequest, orfet_drive_out, line_good_out, output_good_out, power_enable_out;
  logic ref_buffer_en_out, supply_health_ok, clamp_enable_out, fault_flag_out;
  logic [6:0] soft_start_ref_out;
  psu_pkg::trim_t trim_out;
  psu_pkg::cmp_in_t want = 14'h0;
  psu_pkg::cmp_in_t cmp_in;
  int err_total = 0;
  int comparisons = 0;
  // Latching faults, walked in a table: aux ov, iref ov, eref uv, ground, oc, ot.
  int flt[6] = '{5, 8, 9, 10, 11, 12};

  always #4 sys_clk = ~sys_clk;

  // Short undervoltage filter, restart and warning delays keep the run small; delays below follow from them.
  psu_fault_supervisor #(.UV_FILT_CYC(20), .RESTART_CYC(200), .OFF_DELAY_CYC(30)) uut (
    .sys_clk(sys_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cmp_in(cmp_in), .orfet_drive_out(orfet_drive_out),
    .line_good_out(line_good_out), .output_good_out(output_good_out), .power_enable_out(power_enable_out),
    .ref_buffer_en_out(ref_buffer_en_out), .supply_health_ok(supply_health_ok),
    .clamp_enable_out(clamp_enable_out), .fault_flag_out(fault_flag_out),
    .soft_start_ref_out(soft_start_ref_out), .trim_out(trim_out));
  psu_host_model host (.sys_clk(sys_clk), .want(want), .cmp_in(cmp_in));

  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // One Avalon access; the request stands until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    chk("bus answer", 32'h0, {31'h0, avs_waitrequest});
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic set_in(input int i, input logic v);
    @(posedge sys_clk);
    want[i] <= v;
  endtask

  // Raise pulse good, line, upper lockout and power request, then wait for output good.
  task automatic power_up;
    int n;
    n = 0;
    @(posedge sys_clk);
    want <= want | 14'h2083;
    while (output_good_out !== 1'b1 && n < 6000) begin
      @(posedge sys_clk);
      n++;
    end
    chk("ramp code", 32'h7f, soft_start_ref_out);
  endtask

  // Removing the fault alone is not enough; a power request cycle clears the latch.
  task automatic clear_off(input int i);
    set_in(i, 1'b0);
    cyc(2100);
    chk("latch held", 32'h1, fault_flag_out);
    set_in(13, 1'b0);
    cyc(60);
    chk("latch cleared", 32'h0, fault_flag_out);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    bus(1'b0, psu_pkg::REG_TRIM_CLAMP, 32'h0);
    chk("clamp trim reset", 32'h80, rd);
    bus(1'b0, psu_pkg::REG_SS_DIV, 32'h0);
    chk("ramp divider reset", 32'h3e8, rd);
    for (int i = 0; i < 4; i++) bus(1'b1, 8'h08 + 8'(4 * i), 32'h11 * (i + 1));
    bus(1'b1, 8'h40, 32'hff);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped read", 32'h0, rd);
    chk("trim_out", 32'h11223344, trim_out);
    bus(1'b1, psu_pkg::REG_SS_DIV, 32'h0);
  endtask

  task automatic t_power;
    chk("ref buffer early", 32'h0, ref_buffer_en_out);
    power_up();
    chk("ref buffer", 32'h1, ref_buffer_en_out);
    chk("health", 32'h1, supply_health_ok);
    chk("fet on", 32'h1, orfet_drive_out);
    // Status: ramp code 7f, line and health set, state on.
    bus(1'b0, psu_pkg::REG_STATUS, 32'h0);
    chk("status word", 32'h7f32, rd);
  endtask

  task automatic t_line;
    set_in(1, 1'b0);
    set_in(4, 1'b1);
    cyc(100);
    chk("line good low", 32'h0, line_good_out);
    chk("output good kept", 32'h1, output_good_out);
    set_in(4, 1'b0);
    cyc(60);
    set_in(1, 1'b1);
    cyc(60);
    // With blanking disabled, undervoltage at low line is a real latched fault.
    bus(1'b1, psu_pkg::REG_CTRL, 32'h2);
    set_in(1, 1'b0);
    set_in(4, 1'b1);
    cyc(100);
    chk("uv unblanked", 32'h1, fault_flag_out);
    set_in(1, 1'b1);
    clear_off(4);
    bus(1'b1, psu_pkg::REG_CTRL, 32'h0);
    power_up();
  endtask

  task automatic t_fet;
    set_in(0, 1'b0);
    cyc(100);
    set_in(0, 1'b1);
    cyc(1950);
    chk("glitch ignored", 32'h1, orfet_drive_out);
    set_in(0, 1'b0);
    cyc(2100);
    chk("fet without pulse", 32'h0, orfet_drive_out);
    set_in(0, 1'b1);
    set_in(3, 1'b1);
    cyc(2100);
    chk("ov before load ov", 32'h0, fault_flag_out);
    set_in(3, 1'b0);
    set_in(2, 1'b1);
    cyc(2100);
    chk("fet at load ov", 32'h0, orfet_drive_out);
    set_in(2, 1'b0);
    cyc(2100);
    chk("fet back", 32'h1, orfet_drive_out);
    chk("load ov not latched", 32'h0, fault_flag_out);
    set_in(3, 1'b1);
    cyc(2100);
    chk("ov after load ov", 32'h1, fault_flag_out);
    clear_off(3);
  endtask

  task automatic t_faults;
    int n;
    bus(1'b1, psu_pkg::REG_CTRL, 32'h1);
    foreach (flt[k]) begin
      power_up();
      set_in(flt[k], 1'b1);
      n = 0;
      while (output_good_out !== 1'b0 && n < 2200) begin
        @(posedge sys_clk);
        n++;
      end
      chk("enable during warning", 32'h1, power_enable_out);
      cyc(40);
      chk("enable off", 32'h0, power_enable_out);
      chk("fault latch", 32'h1, fault_flag_out);
      if (flt[k] < 11) chk("health", 32'h0, supply_health_ok);
      if (flt[k] == 11) chk("clamp", 32'h0, clamp_enable_out);
      cyc(300);
      chk("no restart", 32'h0, power_enable_out);
      clear_off(flt[k]);
    end
  endtask

  // Undervoltage in auto mode shuts down without latching and comes back by itself.
  task automatic t_restart;
    int n;
    for (int i = 4; i <= 6; i += 2) begin
      power_up();
      set_in(i, 1'b1);
      cyc(100);
      chk("uv shutdown", 32'h0, power_enable_out);
      chk("uv not latched", 32'h0, fault_flag_out);
      set_in(i, 1'b0);
      n = 0;
      while (power_enable_out !== 1'b1 && n < 400) begin
        @(posedge sys_clk);
        n++;
      end
      chk("restarted", 32'h1, power_enable_out);
      chk("restart interval", 32'h1, {31'h0, n > 140});
    end
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    cyc(6);
    reset <= 1'b0;
    t_regs();
    t_power();
    t_line();
    t_fet();
    t_faults();
    t_restart();
    end_sim();
  end

  // The whole run needs about 48000 cycles; the limit leaves margin.
  initial begin
    cyc(90000);
    err_total++;
    $display("[ERR] watchdog expected done seen hang");
    end_sim();
  end
endmodule
`default_nettype wire
